// >>> hdl/conv_timer.sv
// conversion period counter
`timescale 1ns/1ns
`default_nettype none
module conv_timer #(
  parameter int unsigned TENTH_CYCLES = light_pkg::TENTH_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [3:0] convSel,
  output logic busy,
  output logic done
);
  logic [31:0] count;
  logic [31:0] terminal;
  logic [3:0] code;

  // codes above the last one run the longest period
  assign code = (convSel > light_pkg::MAX_CODE) ?
    light_pkg::MAX_CODE : convSel; // RL1
  assign done = busy && (count == terminal - 32'h1);

  // count cycles from start to the terminal of the latched code
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      count <= 32'h0;
      terminal <= 32'h1;
    end else if (ce) begin
      if (start) begin
        busy <= 1'b1;
        count <= 32'h0;
        terminal <= 32'(light_pkg::PERIOD_TENTHS[code]) *
          32'(TENTH_CYCLES); // RL17
      end else if (done) begin
        busy <= 1'b0;
      end else if (busy) begin
        count <= count + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/light_sensor_core.sv
// light conversion timing, result packing, limits and register slave
`timescale 1ns/1ns
`default_nettype none
module light_sensor_core #(
  parameter int unsigned TENTH_CYCLES = light_pkg::TENTH_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire light_pkg::sample_s sample,
  output logic [3:0] gainRange,
  output logic measActive,
  output logic irq
);
  localparam int unsigned IRQ_BITS = light_pkg::IRQ_W;

  light_pkg::state_e state;
  logic [11:0] config_;
  logic [15:0] limHighReg;
  logic [15:0] limLowReg;
  logic [15:0] resHigh;
  logic [7:0] resLow;
  logic [IRQ_BITS-1:0] irqStatus;
  logic [IRQ_BITS-1:0] irqMask;
  logic ack;
  logic [3:0] curRange;
  logic [3:0] autoRange;
  logic [3:0] highRun;
  logic [3:0] lowRun;
  logic flagHigh;
  logic flagLow;
  logic [19:0] capFrac;
  logic [3:0] capCode;
  logic timerBusy;
  logic timerDone;
  logic timerStart;
  logic retake;
  logic faultHigh;
  logic faultLow;
  logic storeNow;
  logic wrHit;
  logic rdHit;
  logic [3:0] next_highRun;
  logic [3:0] next_lowRun;
  logic next_flagHigh;
  logic next_flagLow;
  logic [3:0] convSel;
  logic [3:0] rangeSel;
  logic [1:0] persist;
  logic [1:0] mode;
  logic autoMode;
  logic [3:0] needCount;

  // consecutive faults needed for each persistence setting
  function automatic logic [3:0] persistCount(input logic [1:0] setting);
    persistCount = 4'(4'h1 << setting); // RL15
  endfunction

  // fixed range from the select field, values above 8 held at maximum
  function automatic logic [3:0] fixedRange(input logic [3:0] sel);
    fixedRange = (sel > light_pkg::RANGE_MAX) ?
      light_pkg::RANGE_MAX : sel; // RL13
  endfunction

  // keep only the bits that the conversion period resolves
  function automatic logic [19:0] keepValid(input logic [19:0] frac,
                                            input logic [3:0] code);
    logic [3:0] drop;
    logic [19:0] mask;
    drop = (code > light_pkg::MAX_CODE) ? 4'h0 :
      light_pkg::MIN_DROP - code;
    mask = ~((20'h1 << drop) - 20'h1);
    keepValid = frac & mask; // RL11
  endfunction

  // word index decode, unused; read and write compare the full address
  function automatic logic [3:0] regIndex(input logic [4:0] addr);
    regIndex = {1'b0, addr[4:2]};
  endfunction

  // config fields
  assign convSel = config_[light_pkg::CFG_CONV_LSB +: 4];
  assign rangeSel = config_[light_pkg::CFG_RANGE_LSB +: 4];
  assign persist = config_[light_pkg::CFG_PERSIST_LSB +: 2];
  assign mode = config_[light_pkg::CFG_MODE_LSB +: 2];
  assign autoMode = rangeSel == light_pkg::RANGE_AUTO; // RL13
  assign needCount = persistCount(persist);

  // bus handshake: one wait cycle on every access
  assign avsWaitRequest = (avsRead || avsWrite) && !ack;
  assign wrHit = avsWrite && ack && ce;
  assign rdHit = avsRead && !ack && ce;

  // conversion control terms
  assign retake = sample.overflow && autoMode &&
    (curRange < light_pkg::RANGE_MAX); // RL14
  assign timerStart = ce && (((state == light_pkg::ST_IDLE) &&
    (mode != light_pkg::MODE_OFF)) ||
    ((state == light_pkg::ST_CONV) && timerDone && retake)); // RL2
  assign storeNow = ce && (state == light_pkg::ST_STORE);
  assign gainRange = curRange;
  assign measActive = state != light_pkg::ST_IDLE;
  assign irq = |(irqStatus & irqMask);

  conv_timer #(
    .TENTH_CYCLES(TENTH_CYCLES)
  ) timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .start(timerStart),
    .convSel(convSel),
    .busy(timerBusy),
    .done(timerDone)
  );

  limit_compare compare (
    .fraction(capFrac),
    .exponent(curRange),
    .limHigh(light_pkg::limit_s'(limHighReg)),
    .limLow(light_pkg::limit_s'(limLowReg)),
    .faultHigh(faultHigh),
    .faultLow(faultLow)
  );

  // run counters and flags for the result being stored
  always_comb begin
    next_highRun = faultHigh ?
      ((highRun == 4'h8) ? highRun : highRun + 4'h1) : 4'h0;
    next_lowRun = faultLow ?
      ((lowRun == 4'h8) ? lowRun : lowRun + 4'h1) : 4'h0;
    next_flagHigh = next_highRun >= needCount; // RL10
    next_flagLow = next_lowRun >= needCount; // RL10
  end

  // bus acknowledge toggles once per request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= (avsRead || avsWrite) && !ack;
    end
  end

  // read data latched in the wait cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avsReadData <= 32'h0;
    end else if (rdHit) begin
      if (avsAddress == light_pkg::OFS_CONFIG) begin
        avsReadData <= 32'(config_);
      end else if (avsAddress == light_pkg::OFS_RES_HI) begin
        avsReadData <= 32'(resHigh); // RL5
      end else if (avsAddress == light_pkg::OFS_RES_LO) begin
        avsReadData <= 32'(resLow); // RL5
      end else if (avsAddress == light_pkg::OFS_LIM_HI) begin
        avsReadData <= 32'(limHighReg);
      end else if (avsAddress == light_pkg::OFS_LIM_LO) begin
        avsReadData <= 32'(limLowReg);
      end else if (avsAddress == light_pkg::OFS_STATUS) begin
        avsReadData <= 32'({autoRange, curRange, timerBusy,
          measActive, flagLow, flagHigh});
      end else if (avsAddress == light_pkg::OFS_IRQ_STAT) begin
        avsReadData <= 32'(irqStatus);
      end else if (avsAddress == light_pkg::OFS_IRQ_MASK) begin
        avsReadData <= 32'(irqMask);
      end else begin
        avsReadData <= 32'h0; // unmapped reads as zero
      end
    end
  end

  // configuration, one-shot mode cleared by hardware after the store
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      config_ <= light_pkg::CFG_RESET;
    end else if (wrHit && (avsAddress == light_pkg::OFS_CONFIG)) begin
      config_ <= avsWriteData[11:0];
    end else if (storeNow && (mode == light_pkg::MODE_ONESHOT)) begin
      config_[light_pkg::CFG_MODE_LSB +: 2] <= light_pkg::MODE_OFF;
    end
  end

  // limit registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      limHighReg <= light_pkg::LIM_HI_RESET;
      limLowReg <= light_pkg::LIM_LO_RESET;
    end else if (wrHit) begin
      if (avsAddress == light_pkg::OFS_LIM_HI) begin
        limHighReg <= avsWriteData[15:0]; // RL7
      end else if (avsAddress == light_pkg::OFS_LIM_LO) begin
        limLowReg <= avsWriteData[15:0]; // RL7
      end
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqMask <= '0;
    end else if (wrHit && (avsAddress == light_pkg::OFS_IRQ_MASK)) begin
      irqMask <= avsWriteData[IRQ_BITS-1:0];
    end
  end

  // sticky interrupt status, a new event wins over a write of one
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus <= '0;
    end else if (ce) begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (wrHit && (avsAddress == light_pkg::OFS_IRQ_STAT) &&
            avsWriteData[i]) begin
          irqStatus[i] <= 1'b0;
        end
      end
      if (storeNow) begin
        irqStatus[light_pkg::IRQ_DONE] <= 1'b1;
        if (next_flagHigh && !flagHigh) begin
          irqStatus[light_pkg::IRQ_HIGH] <= 1'b1;
        end
        if (next_flagLow && !flagLow) begin
          irqStatus[light_pkg::IRQ_LOW] <= 1'b1;
        end
      end
    end
  end

  // measurement sequence
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= light_pkg::ST_IDLE;
    end else if (ce) begin
      case (state)
        light_pkg::ST_IDLE: begin
          if (timerStart) begin
            state <= light_pkg::ST_CONV;
          end
        end
        light_pkg::ST_CONV: begin
          if (timerDone && !retake) begin
            state <= light_pkg::ST_STORE; // RL14
          end
        end
        light_pkg::ST_STORE: begin
          state <= light_pkg::ST_IDLE;
        end
        default: begin
          state <= light_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // range used by the running measurement
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      curRange <= 4'h0;
    end else if (ce) begin
      if ((state == light_pkg::ST_IDLE) && timerStart) begin
        curRange <= autoMode ? autoRange : fixedRange(rangeSel); // RL4
      end else if ((state == light_pkg::ST_CONV) && timerDone &&
                   retake) begin
        curRange <= curRange + 4'h1; // RL14
      end
    end
  end

  // automatic range carried to the next measurement
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      autoRange <= light_pkg::RANGE_MAX;
    end else if (ce) begin
      if (!autoMode) begin
        autoRange <= fixedRange(rangeSel);
      end else if (storeNow) begin
        if ((capFrac[19:18] == 2'h0) && (curRange != 4'h0)) begin
          autoRange <= curRange - 4'h1; // low side, step down
        end else if ((capFrac[19:18] == 2'h3) &&
                     (curRange < light_pkg::RANGE_MAX)) begin
          autoRange <= curRange + 4'h1; // high side, step up
        end else begin
          autoRange <= curRange;
        end
      end
    end
  end

  // capture the front-end code at the end of the period; the code is
  // latched at start so the mask matches the period really timed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      capFrac <= 20'h0;
      capCode <= 4'h0;
    end else if (ce) begin
      if (timerStart && (state == light_pkg::ST_IDLE)) begin
        capCode <= convSel;
      end
      if ((state == light_pkg::ST_CONV) && timerDone && !retake) begin
        capFrac <= keepValid(sample.overflow ? 20'hFFFFF : sample.code,
          capCode); // RL3 RL11
      end
    end
  end

  // result registers written at the end of the conversion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      resHigh <= 16'h0;
      resLow <= 8'h0;
    end else if (storeNow) begin
      resHigh <= {curRange, capFrac[19:8]}; // RL2 RL3 RL4 RL5
      resLow <= capFrac[7:0]; // RL5
    end
  end

  // fault runs and flags after each stored result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      highRun <= 4'h0;
      lowRun <= 4'h0;
      flagHigh <= 1'b0;
      flagLow <= 1'b0;
    end else if (storeNow) begin
      highRun <= next_highRun; // RL9
      lowRun <= next_lowRun; // RL9
      flagHigh <= next_flagHigh; // RL10
      flagLow <= next_flagLow; // RL10
    end
  end
endmodule
`default_nettype wire

// >>> hdl/limit_compare.sv
// expansion of both limits and fault comparison
`timescale 1ns/1ns
`default_nettype none
module limit_compare (
  input wire logic [19:0] fraction,
  input wire logic [3:0] exponent,
  input wire light_pkg::limit_s limHigh,
  input wire light_pkg::limit_s limLow,
  output logic faultHigh,
  output logic faultLow
);
  logic [35:0] linear;
  logic [35:0] highLin;
  logic [35:0] lowLin;

  // linear value and zero-padded limits on one wide scale
  assign linear = 36'(fraction) << exponent; // RL6 RL12
  assign highLin = 36'(limHigh.significand) <<
    (light_pkg::LIMIT_PAD + 6'(limHigh.exponent)); // RL7 RL8
  assign lowLin = 36'(limLow.significand) <<
    (light_pkg::LIMIT_PAD + 6'(limLow.exponent)); // RL8
  assign faultHigh = linear > highLin; // RL16
  assign faultLow = linear < lowLin; // RL16
endmodule
`default_nettype wire

// >>> include/light_pkg.sv
// constants, types and register map of the light result and threshold block
//
// Contract
// RL1: a conversion select field of codes 0 to 11 picks 0.6, 1, 1.8, 3.4, 6.5, 12.7, 25, 50, 100, 200, 400 or 800 ms.
// RL2: the period runs from measurement start, as the mode sets it, until the result is written to the result registers.
// RL3: every result is a 4-bit scale exponent with a 20-bit linear fraction proportional to the light in that range.
// RL4: the reported exponent is the range really used, whether chosen automatically or set by hand.
// RL5: the upper result register holds the top 12 fraction bits and the lower one the bottom 8 bits.
// RL6: the linear light value is the fraction shifted left by the exponent, up to 28 bits for exponent 8.
// RL7: each of the high and low limits is a 12-bit significand with a 4-bit exponent.
// RL8: a limit is expanded for comparison by shifting its significand left by 8 plus its exponent.
// RL9: after every conversion the linear value is compared with both limits to find high or low fault events.
// RL10: the high and low flags set only once the persistence count of consecutive fault events is reached.
// RL11: valid fraction bits grow from 9 at code 0 to 20 at code 11, and unused low bits read as zero.
// RL12: the weight of one step of the linear value is the same for every conversion period.
// RL13: range values 0 to 8 fix the full-scale range and value 12 selects the range automatically.
// RL14: in automatic range an overflowing measurement is dropped, the range stepped up if below maximum, and retaken.
// RL15: the persistence setting maps to counts 1, 2, 4 and 8, so setting 2 needs four faults in a row.
// RL16: a high fault is a linear value above the high limit and a low fault one below the low limit.
// RL17: the period is counted on the block clock with a terminal count per select code.
package light_pkg;
  // clock and conversion timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TENTH_MS_CYCLES = CLK_MHZ * 100;
  localparam int unsigned NUM_CODES = 12;
  localparam logic [3:0] MAX_CODE = 4'hB;
  // periods in tenths of a millisecond, code 0 first
  localparam logic [13:0] PERIOD_TENTHS [NUM_CODES] = '{
    14'h0006, 14'h000A, 14'h0012, 14'h0022, 14'h0041, 14'h007F,
    14'h00FA, 14'h01F4, 14'h03E8, 14'h07D0, 14'h0FA0, 14'h1F40};
  // data widths
  localparam int unsigned FRAC_W = 20;
  localparam int unsigned LIN_W = 28;
  localparam int unsigned CMP_W = 36;
  localparam logic [3:0] MIN_DROP = 4'hB; // low bits dropped at code 0
  localparam logic [3:0] RANGE_MAX = 4'h8;
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [5:0] LIMIT_PAD = 6'h08;
  // register byte offsets
  localparam logic [4:0] OFS_CONFIG = 5'h00;
  localparam logic [4:0] OFS_RES_HI = 5'h04;
  localparam logic [4:0] OFS_RES_LO = 5'h08;
  localparam logic [4:0] OFS_LIM_HI = 5'h0C;
  localparam logic [4:0] OFS_LIM_LO = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1C;
  // config fields
  localparam int unsigned CFG_CONV_LSB = 0;
  localparam int unsigned CFG_RANGE_LSB = 4;
  localparam int unsigned CFG_PERSIST_LSB = 8;
  localparam int unsigned CFG_MODE_LSB = 10;
  localparam logic [11:0] CFG_RESET = 12'h0C8;
  localparam logic [15:0] LIM_HI_RESET = 16'hBFFF;
  localparam logic [15:0] LIM_LO_RESET = 16'h0000;
  // modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  // interrupt bits
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_HIGH = 1;
  localparam int unsigned IRQ_LOW = 2;
  localparam int unsigned IRQ_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b100
  } state_e;

  typedef struct packed {
    logic [3:0] exponent;
    logic [11:0] significand;
  } limit_s;

  typedef struct packed {
    logic overflow;
    logic [19:0] code;
  } sample_s;
endpackage

// >>> testbench/light_front_end.sv
// behavioural model of the optical front end feeding the block
`timescale 1ns/1ns
`default_nettype none
module light_front_end (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic measActive,
  input wire logic [3:0] gainRange,
  input wire logic [27:0] level,
  output var light_pkg::sample_s sample
);
  logic [27:0] scaled;
  assign scaled = level >> gainRange;
  // scaled light while converting; a changing pattern when idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sample <= '0;
    end else if (measActive) begin
      sample.overflow <= scaled > 28'h00FFFFF;
      sample.code <= scaled[19:0];
    end else begin
      sample <= ~sample;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/light_sensor_core_tb.sv
// self-checking bench for the light conversion and threshold block
`timescale 1ns/1ns
`default_nettype none
module light_sensor_core_tb;
  localparam int unsigned TC = 1; // cycles per tenth of a millisecond
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  light_pkg::sample_s sample;
  logic [3:0] gainRange;
  logic measActive;
  logic irq;
  logic [27:0] level = 28'h0000000;
  logic [31:0] rd;
  int mismatches = 0;
  int nCompared = 0;
  always #2 ref_clk = ~ref_clk;
  light_sensor_core #(.TENTH_CYCLES(TC)) light_sensor_core_i (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .sample(sample), .gainRange(gainRange), .measActive(measActive),
    .irq(irq));
  light_front_end light_front_end_i (.ref_clk(ref_clk), .resetn(resetn),
    .measActive(measActive), .gainRange(gainRange), .level(level),
    .sample(sample));
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic busWrite(input logic [4:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= 1'b1;
    @(posedge ref_clk);
    while (avsWaitRequest !== 1'b0) @(posedge ref_clk);
    avsWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic busRead(input logic [4:0] a);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge ref_clk);
    while (avsWaitRequest !== 1'b0) @(posedge ref_clk);
    rd = avsReadData;
    avsRead <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one-shot measurement at the given light, waits for it to finish
  task automatic measure(input logic [11:0] cfg, input logic [27:0] lux);
    int t;
    t = 0;
    level <= lux;
    busWrite(light_pkg::OFS_CONFIG, {20'h00000, cfg});
    while (measActive !== 1'b1 && t < 20) begin
      @(posedge ref_clk);
      t++;
    end
    while (measActive !== 1'b0 && t < 20000) begin
      @(posedge ref_clk);
      t++;
    end
    if (t >= 20000) check("measurement end", 32'h1, 32'h0);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic result(input logic [3:0] e, input logic [19:0] f);
    busRead(light_pkg::OFS_RES_HI);
    check("result high", {16'h0000, e, f[19:8]}, rd);
    busRead(light_pkg::OFS_RES_LO);
    check("result low", {24'h000000, f[7:0]}, rd);
  endtask
  task automatic resetValues();
    busRead(light_pkg::OFS_CONFIG);
    check("config", 32'h000000C8, rd);
    busRead(light_pkg::OFS_LIM_HI);
    check("high limit", 32'h0000BFFF, rd);
    busRead(light_pkg::OFS_LIM_LO);
    check("low limit", 32'h00000000, rd);
    busWrite(5'h02, 32'h00000FFF);
    busWrite(light_pkg::OFS_RES_HI, 32'h0000FFFF);
    busRead(5'h02);
    check("unmapped", 32'h00000000, rd);
    busRead(light_pkg::OFS_RES_HI);
    check("read-only result", 32'h00000000, rd);
  endtask
  task automatic autoRange();
    for (int i = 0; i < 9; i++) begin
      measure(12'h4C0, 28'h0000100);
      result(4'(8 - i), 20'h00000);
    end
    measure(12'h4C0, 28'h0FFFFF0);
    result(4'h4, 20'hFF800);
  endtask
  task automatic convTimes();
    for (int c = 0; c < 12; c++) begin
      measure({8'h43, 4'(c)}, 28'h055E6F0);
      result(4'h3, 20'hABCDE & (20'hFFFFF << (11 - c)));
    end
  endtask
  task automatic rangeLinear();
    for (int r = 0; r < 9; r++) begin
      measure({4'h4, 4'(r), 4'h7}, 28'h00FF800);
      result(4'(r), 20'((28'h00FF800 >> r) & 28'h00FFFF0));
    end
  endtask
  task automatic persistence();
    busWrite(light_pkg::OFS_LIM_HI, 32'h00000010);
    busWrite(light_pkg::OFS_IRQ_MASK, 32'h00000002);
    busWrite(light_pkg::OFS_IRQ_STAT, 32'h00000007);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < (1 << p); k++) begin
        measure({2'h1, 2'(p), 8'h00}, 28'h0001800);
        busRead(light_pkg::OFS_STATUS);
        check("high flag", 32'(k == (1 << p) - 1), 32'(rd[0]));
        check("irq high", 32'(k == (1 << p) - 1), 32'(irq));
      end
      busWrite(light_pkg::OFS_IRQ_STAT, 32'h00000002);
      check("irq cleared", 32'h0, 32'(irq));
      measure({2'h1, 2'(p), 8'h00}, 28'h0001000);
      busRead(light_pkg::OFS_STATUS);
      check("equal not high", 32'h0, 32'(rd[0]));
    end
  endtask
  task automatic lowFault();
    busWrite(light_pkg::OFS_LIM_HI, 32'h0000BFFF);
    busWrite(light_pkg::OFS_LIM_LO, 32'h00001010);
    busWrite(light_pkg::OFS_IRQ_MASK, 32'h00000004);
    measure(12'h400, 28'h0001800);
    busRead(light_pkg::OFS_STATUS);
    check("low flags", 32'h2, 32'(rd[1:0]));
    check("irq low", 32'h1, 32'(irq));
    measure(12'h400, 28'h0002000);
    busRead(light_pkg::OFS_STATUS);
    check("equal not low", 32'h0, 32'(rd[1:0]));
    busWrite(light_pkg::OFS_IRQ_STAT, 32'h00000004);
    check("irq low cleared", 32'h0, 32'(irq));
  endtask
  // continuous mode frozen by the clock enable, then stopped
  task automatic freezeRun();
    busWrite(light_pkg::OFS_IRQ_STAT, 32'h00000007);
    busWrite(light_pkg::OFS_CONFIG, 32'h00000890);
    repeat (3) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check("frozen range", 32'h8, 32'(gainRange));
    check("frozen active", 32'h1, 32'(measActive));
    ce <= 1'b1;
    repeat (20) @(posedge ref_clk);
    busWrite(light_pkg::OFS_CONFIG, 32'h00000090);
    repeat (10) @(posedge ref_clk);
    busRead(light_pkg::OFS_IRQ_STAT);
    check("events", 32'h5, rd);
    busRead(light_pkg::OFS_STATUS);
    check("stopped", 32'h880, rd & 32'h00000FFC);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    resetValues();
    autoRange();
    convTimes();
    rangeLinear();
    persistence();
    lowFault();
    freezeRun();
    conclude();
  end
  // cuts a hang short well after the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
endmodule
bind light_sensor_core light_sensor_properties #(
  .TENTH_CYCLES(TENTH_CYCLES)) light_sensor_properties_i (
  .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .sample(sample), .gainRange(gainRange), .measActive(measActive),
  .irq(irq));
`default_nettype wire

// >>> testbench/light_sensor_properties.sv
// port assertions for the light conversion and threshold block
`timescale 1ns/1ns
`default_nettype none
module light_sensor_properties #(
  parameter int unsigned TENTH_CYCLES = light_pkg::TENTH_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire light_pkg::sample_s sample,
  input wire logic [3:0] gainRange,
  input wire logic measActive,
  input wire logic irq
);
  logic [3:0] cfgCode;
  logic [3:0] cfgRange;
  logic [3:0] runCode;
  logic [3:0] runRange;
  logic runAuto;
  int unsigned activeCnt;
  int unsigned expCnt;
  // shadow of the conversion and range fields
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfgCode <= 4'h8;
      cfgRange <= 4'hC;
    end else if (ce && avsWrite && !avsWaitRequest &&
                 avsAddress == light_pkg::OFS_CONFIG) begin
      cfgCode <= avsWriteData[3:0];
      cfgRange <= avsWriteData[7:4];
    end
  end
  // settings caught at start and length of each measurement
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      runCode <= 4'h0;
      runRange <= 4'h0;
      runAuto <= 1'b0;
      activeCnt <= 0;
    end else if (ce && !measActive) begin
      runCode <= cfgCode > light_pkg::MAX_CODE ? light_pkg::MAX_CODE : cfgCode;
      runRange <= cfgRange > light_pkg::RANGE_MAX ? light_pkg::RANGE_MAX
                                                  : cfgRange;
      runAuto <= cfgRange == light_pkg::RANGE_AUTO;
      activeCnt <= 0;
    end else if (ce) begin
      activeCnt <= activeCnt + 1;
    end
  end
  assign expCnt = light_pkg::PERIOD_TENTHS[runCode] * TENTH_CYCLES + 1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence oneWait;
    avsWaitRequest ##1 !avsWaitRequest;
  endsequence
  bus_wait_a: assert property (ce && $rose(avsRead || avsWrite) |-> oneWait)
    else $error("request not answered after one wait cycle");
  bus_idle_a: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
    else $error("waitrequest without request");
  rdata_hold_a: assert property (!(avsRead && avsWaitRequest) |=>
    $stable(avsReadData)) else $error("read data moved without a read");
  unmapped_zero_a: assert property (avsRead && !avsWaitRequest &&
    avsAddress[1:0] != 2'h0 |-> avsReadData == 32'h00000000)
    else $error("unmapped read not zero");
  conv_period_a: assert property ($fell(measActive) |->
    (runAuto ? activeCnt >= expCnt : activeCnt == expCnt))
    else $error("measurement length wrong");
  fixed_range_a: assert property ($rose(measActive) && !runAuto |=>
    gainRange == runRange) else $error("fixed range not applied");
  range_steady_a: assert property (measActive && activeCnt >= 2 &&
    !runAuto |-> $stable(gainRange)) else $error("range moved in a run");
  irq_rise_a: assert property ($rose(irq) |->
    $past(measActive) || $past(avsWrite)) else $error("irq rose uncaused");
  irq_fall_a: assert property ($fell(irq) |-> $past(avsWrite))
    else $error("irq fell without a write");
endmodule
`default_nettype wire
